// file: src/rca_defs.svh
`ifndef RCA_DEFS_SVH
`define RCA_DEFS_SVH
// ***********************************************
// register addresses
// ***********************************************
`define RCA_ADDR_TRIM 20'hfff99
`define RCA_ADDR_AMIN 20'hfff9a
`define RCA_ADDR_AHOUR 20'hfff9b
`define RCA_ADDR_AWDAY 20'hfff9c
`define RCA_ADDR_MONTH 20'hfff9d
`define RCA_ADDR_YEAR 20'hfff9e
// ***********************************************
// reset values
// ***********************************************
`define RCA_RST_TRIM 8'h00
`define RCA_RST_AMIN 8'h00
`define RCA_RST_AHOUR 8'h12
`define RCA_RST_AWDAY 8'h00
`define RCA_RST_MONTH 8'h01
`define RCA_RST_YEAR 8'h00
// ***********************************************
// field positions and calendar constants
// ***********************************************
`define RCA_TRIM_DEV 7
`define RCA_TRIM_SIGN 6
`define RCA_HOUR_PM 5
`define RCA_PRESC_NOMINAL 16'h7fff
`define RCA_MONTH_FIRST 8'h01
`define RCA_MONTH_LAST 8'h12
`define RCA_MONTH_FEB 8'h02
`define RCA_YEAR_FIRST 8'h00
`define RCA_YEAR_LAST 8'h99
`define RCA_SEC_00 8'h00
`define RCA_SEC_20 8'h20
`define RCA_SEC_40 8'h40
`define RCA_XFER_CYCLES 2'h2
`endif

// file: src/rca_pkg.sv
package rca_pkg;
  // lower counters snapshot
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
  } rca_time_s;
  typedef struct packed {
    logic dev;
    logic sign;
    logic [5:0] mag;
  } rca_trim_s;
endpackage

// file: src/rca_top.sv
`timescale 1ns/1ps
`include "rca_defs.svh"
module rca_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // register access
  input wire logic [19:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // lower counters
  input wire rca_pkg::rca_time_s cur_time,
  input wire logic day_wrap,
  input wire logic hour_format_select,
  input wire logic alarm_match_enable,
  input wire logic counter_run,
  // outputs to lower counters and interrupt
  output logic [15:0] presc_terminal,
  output logic is_leap_year,
  output logic is_february,
  output logic alarm_hit
);
  // ***********************************************
  // registers
  // ***********************************************
  logic [7:0] trim_r, amin_r, ahour_r, awday_r, month_r, year_r;
  logic [7:0] mbuf_r, ybuf_r;
  logic [1:0] mcnt_r, ycnt_r;
  logic fmt_seen_r, alarm_hit_r;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  // ***********************************************
  // decode
  // ***********************************************
  wire sel_trim = reg_wr && (reg_addr == `RCA_ADDR_TRIM);
  wire sel_amin = reg_wr && (reg_addr == `RCA_ADDR_AMIN);
  wire sel_ahour = reg_wr && (reg_addr == `RCA_ADDR_AHOUR);
  wire sel_awday = reg_wr && (reg_addr == `RCA_ADDR_AWDAY);
  wire sel_month = reg_wr && (reg_addr == `RCA_ADDR_MONTH);
  wire sel_year = reg_wr && (reg_addr == `RCA_ADDR_YEAR);

  always_comb begin
    if (reg_addr == `RCA_ADDR_TRIM) reg_rdata = trim_r;
    else if (reg_addr == `RCA_ADDR_AMIN) reg_rdata = amin_r;
    else if (reg_addr == `RCA_ADDR_AHOUR) reg_rdata = ahour_r;
    else if (reg_addr == `RCA_ADDR_AWDAY) reg_rdata = awday_r;
    else if (reg_addr == `RCA_ADDR_MONTH) reg_rdata = month_r;
    else if (reg_addr == `RCA_ADDR_YEAR) reg_rdata = year_r;
    else reg_rdata = 8'h00;
  end

  // ***********************************************
  // calendar
  // ***********************************************
  wire month_pend = (mcnt_r != 2'h0) || sel_month;
  wire year_pend = (ycnt_r != 2'h0) || sel_year;
  wire month_wrap = day_wrap && counter_run && (month_r == `RCA_MONTH_LAST);
  assign is_leap_year = ~year_r[0] && (year_r[1] == year_r[4]);
  assign is_february = (month_r == `RCA_MONTH_FEB);

  logic [7:0] month_nxt, year_nxt;
  always_comb begin
    month_nxt = month_r;
    if (mcnt_r == 2'h1) month_nxt = mbuf_r;
    else if (!month_pend && day_wrap && counter_run)
      month_nxt = month_wrap ? `RCA_MONTH_FIRST : bcd_inc(month_r);
  end

  always_comb begin
    year_nxt = year_r;
    if (ycnt_r == 2'h1) year_nxt = ybuf_r;
    else if (!year_pend && month_wrap && !month_pend)
      year_nxt = (year_r == `RCA_YEAR_LAST) ? `RCA_YEAR_FIRST : bcd_inc(year_r);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      month_r <= `RCA_RST_MONTH;
      year_r <= `RCA_RST_YEAR;
      mbuf_r <= `RCA_RST_MONTH;
      ybuf_r <= `RCA_RST_YEAR;
      mcnt_r <= 2'h0;
      ycnt_r <= 2'h0;
    end else begin
      month_r <= month_nxt;
      year_r <= year_nxt;
      if (sel_month) begin
        mbuf_r <= reg_wdata;
        mcnt_r <= `RCA_XFER_CYCLES;
      end else if (mcnt_r != 2'h0) begin
        mcnt_r <= mcnt_r - 2'h1;
      end
      if (sel_year) begin
        ybuf_r <= reg_wdata;
        ycnt_r <= `RCA_XFER_CYCLES;
      end else if (ycnt_r != 2'h0) begin
        ycnt_r <= ycnt_r - 2'h1;
      end
    end
  end

  // ***********************************************
  // watch error correction
  // ***********************************************
  rca_pkg::rca_trim_s trim;
  assign trim = rca_pkg::rca_trim_s'(trim_r);
  wire trim_sec = trim.dev ? (cur_time.sec == `RCA_SEC_00) :
                  ((cur_time.sec == `RCA_SEC_00) || (cur_time.sec == `RCA_SEC_20) ||
                   (cur_time.sec == `RCA_SEC_40));
  wire trim_on = trim_sec && (trim.mag[5:1] != 5'h00);
  wire [15:0] trim_add = {9'h000, trim.mag - 6'h01, 1'b0};
  wire [15:0] trim_sub = {9'h000, (~trim.mag) + 6'h01, 1'b0};
  logic [15:0] presc_nxt;
  // signed correction of two counts per step
  assign presc_nxt = !trim_on ? `RCA_PRESC_NOMINAL :
                     trim.sign ? (`RCA_PRESC_NOMINAL - trim_sub) :
                     (`RCA_PRESC_NOMINAL + trim_add);

  // ***********************************************
  // alarm registers and compare
  // ***********************************************
  // minute range check
  wire amin_ok = bcd_ok(amin_r, 8'h00, 8'h59);
  wire ahour_ok = hour_format_select ? bcd_ok(ahour_r, 8'h00, 8'h23) :
                  (bcd_ok(ahour_r, 8'h01, 8'h12) || bcd_ok(ahour_r, 8'h21, 8'h32));
  wire wday_ok = (cur_time.wday < 8'h07) && awday_r[cur_time.wday[2:0]];
  wire alarm_match = alarm_match_enable && amin_ok && ahour_ok && wday_ok &&
                     (cur_time.min == amin_r) && (cur_time.hour == ahour_r);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trim_r <= `RCA_RST_TRIM;
      amin_r <= `RCA_RST_AMIN;
      ahour_r <= `RCA_RST_AHOUR;
      awday_r <= `RCA_RST_AWDAY;
      fmt_seen_r <= 1'b0;
      presc_terminal <= `RCA_PRESC_NOMINAL;
      alarm_hit_r <= 1'b0;
    end else begin
      presc_terminal <= presc_nxt;
      alarm_hit_r <= alarm_match;
      if (sel_trim) trim_r <= reg_wdata;
      if (sel_amin) amin_r <= {1'b0, reg_wdata[6:0]};
      if (sel_awday) awday_r <= {1'b0, reg_wdata[6:0]};
      if (sel_ahour) begin
        ahour_r <= {2'b00, reg_wdata[5:0]};
      // first switch to 24-hour clears reset value
      end else if (hour_format_select && !fmt_seen_r &&
                   ahour_r == `RCA_RST_AHOUR) begin
        ahour_r <= 8'h00;
      end
      if (hour_format_select || sel_ahour) fmt_seen_r <= 1'b1;
    end
  end

  // level match event for the shared interrupt status
  assign alarm_hit = alarm_hit_r;
endmodule

// file: sim/rca_top_sva.sv
`timescale 1ns/1ps
module rca_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // watched ports
  input wire rca_pkg::rca_time_s cur_time,
  input wire logic alarm_match_enable,
  input wire logic [15:0] presc_terminal,
  input wire logic alarm_hit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ****
  // properties
  // ****
  sequence quiet_sec;
    !(cur_time.sec inside {8'h00, 8'h20, 8'h40}) ##1 $stable(cur_time.sec);
  endsequence
  AST_PRESC_NOM: assert property (quiet_sec |-> presc_terminal == 16'h7fff)
    else $error("terminal moved outside correction seconds");
  AST_PRESC_SPAN: assert property (presc_terminal inside {[16'h7f83:16'h807b]})
    else $error("terminal beyond correction span");
  AST_RST_STATE: assert property ($rose(rstn) |-> presc_terminal == 16'h7fff && !alarm_hit)
    else $error("bad state after reset");
  AST_EN_OFF: assert property ($fell(alarm_match_enable) |=> !alarm_hit)
    else $error("hit kept after disable");
  AST_HIT_EN: assert property (alarm_hit |-> $past(alarm_match_enable))
    else $error("hit while disabled");
  AST_MIN_OK: assert property (alarm_hit |-> $past(cur_time.min) <= 8'h59)
    else $error("hit on bad minute");
  AST_HOUR_OK: assert property (alarm_hit |-> $past(cur_time.hour) <= 8'h32)
    else $error("hit on bad hour");
  AST_WDAY_OK: assert property (alarm_hit |-> $past(cur_time.wday) <= 8'h06)
    else $error("hit on bad weekday");
endmodule
bind rca_top rca_top_sva i_rca_top_sva (.sys_clk(sys_clk), .rstn(rstn), .cur_time(cur_time),
  .alarm_match_enable(alarm_match_enable), .presc_terminal(presc_terminal),
  .alarm_hit(alarm_hit));

// file: sim/test_rca_top.sv
`timescale 1ns/1ps
module test_rca_top;
  logic sys_clk = 0, rstn = 0, reg_wr = 0, day_wrap = 0;
  logic hour_format_select = 0, alarm_match_enable = 0, counter_run = 1;
  logic [19:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata;
  rca_pkg::rca_time_s cur_time = '0;
  logic [15:0] presc_terminal;
  logic is_leap_year, is_february, alarm_hit;
  int fails = 0, compares = 0;
  // {trim, seconds, expected terminal}
  logic [31:0] tab [8] = '{32'h05208007, 32'h05157fff, 32'h85207fff, 32'h85008007,
    32'h7c407ff7, 32'h41007fff, 32'h3f00807b, 32'h40207fff};
  always #25 sys_clk = ~sys_clk;
  rca_top i_rca_top (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cur_time(cur_time), .day_wrap(day_wrap),
    .hour_format_select(hour_format_select), .alarm_match_enable(alarm_match_enable),
    .counter_run(counter_run), .presc_terminal(presc_terminal), .is_leap_year(is_leap_year),
    .is_february(is_february), .alarm_hit(alarm_hit));
  // ****
  // helpers
  // ****
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_b(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one cycle of write strobe and/or day wrap
  task op(input logic [19:0] a, input logic [7:0] d, input logic w, input logic dw);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    day_wrap = dw;
    cyc(1);
    reg_wr = 0;
    day_wrap = 0;
  endtask
  task rd(input logic [19:0] a, input logic [7:0] exp);
    cyc(2);
    reg_addr = a;
    #1 chk({8'h0, reg_rdata}, {8'h0, exp});
  endtask
  task hit(input logic [23:0] t, input logic exp);
    cur_time = {8'h15, t};
    cyc(2);
    chk_b(alarm_hit, exp);
  endtask
  // ****
  // scenarios
  // ****
  task t_reset;
    rd(20'hfff99, 8'h00);
    rd(20'hfff9a, 8'h00);
    rd(20'hfff9b, 8'h12);
    rd(20'hfff9c, 8'h00);
    rd(20'hfff9d, 8'h01);
    rd(20'hfff9e, 8'h00);
    chk_b(is_leap_year, 1'b1);
    op(20'hfff9f, 8'h5a, 1, 0);
    rd(20'hfff9f, 8'h00);
    hour_format_select = 1;
    rd(20'hfff9b, 8'h00);
    $display("reset test done");
  endtask
  task t_trim;
    foreach (tab[i]) begin
      cur_time.sec = 8'h15;
      op(20'hfff99, tab[i][31:24], 1, 0);
      cur_time.sec = tab[i][23:16];
      cyc(3);
      chk(presc_terminal, tab[i][15:0]);
    end
    cur_time.sec = 8'h15;
    $display("trim test done");
  endtask
  task t_cal;
    op(20'hfff9d, 8'h12, 1, 0);
    rd(20'hfff9d, 8'h12);
    op(20'hfff9e, 8'h99, 1, 0);
    rd(20'hfff9e, 8'h99);
    chk_b(is_leap_year, 1'b0);
    op(20'h0, 8'h0, 0, 1);
    rd(20'hfff9d, 8'h01);
    rd(20'hfff9e, 8'h00);
    op(20'hfff9d, 8'h05, 1, 1);
    rd(20'hfff9d, 8'h05);
    op(20'hfff9d, 8'h12, 1, 0);
    rd(20'hfff9d, 8'h12);
    op(20'hfff9e, 8'h07, 1, 1);
    rd(20'hfff9e, 8'h07);
    rd(20'hfff9d, 8'h01);
    op(20'hfff9e, 8'h96, 1, 0);
    op(20'h0, 8'h0, 0, 1);
    cyc(2);
    chk_b(is_february, 1'b1);
    chk_b(is_leap_year, 1'b1);
    // counters held: day wrap ignored while stopped
    counter_run = 0;
    op(20'h0, 8'h0, 0, 1);
    rd(20'hfff9d, 8'h02);
    counter_run = 1;
    $display("calendar test done");
  endtask
  task t_alarm;
    op(20'hfff9a, 8'h30, 1, 0);
    op(20'hfff9b, 8'h13, 1, 0);
    op(20'hfff9c, 8'h02, 1, 0);
    alarm_match_enable = 1;
    hit(24'h301301, 1);
    hit(24'h301300, 0);
    hit(24'h311301, 0);
    hour_format_select = 0;
    hit(24'h301301, 0);
    alarm_match_enable = 0;
    hour_format_select = 1;
    hit(24'h301301, 0);
    op(20'hfff9a, 8'h60, 1, 0);
    alarm_match_enable = 1;
    hit(24'h601301, 0);
    alarm_match_enable = 0;
    hour_format_select = 0;
    op(20'hfff9a, 8'h00, 1, 0);
    op(20'hfff9b, 8'h32, 1, 0);
    op(20'hfff9c, 8'h7f, 1, 0);
    alarm_match_enable = 1;
    hit(24'h003206, 1);
    hit(24'h001206, 0);
    $display("alarm test done");
  endtask
  task final_report;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(16);
    rstn = 1;
    t_reset;
    t_trim;
    t_cal;
    t_alarm;
    final_report;
  end
  initial begin
    #200000;
    fails++;
    final_report;
  end
endmodule
